//--- rtl/mcs_consts.svh
// Constants for the motion command sequencer: defaults, codes, timing counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MCS_CONSTS_SVH
`define MCS_CONSTS_SVH

`define MCS_CLK_PERIOD_NS      10
`define MCS_POS_W              24
`define MCS_SPD_W              12
`define MCS_ENTRIES            16
`define MCS_SEL_W              4
`define MCS_SPD_MAX            12'd4000
`define MCS_JOG_SPD_DEF        12'd300
`define MCS_JOG_RAMP_MS_DEF    16'd100
`define MCS_JOG_TRQ_DEF        8'd100
`define MCS_JOG_TRQ_MAX        8'd250
`define MCS_JOG_STEPS_DEF      24'h000001
`define MCS_SOFT_LIM_POS_DEF   24'h7fffff
`define MCS_SOFT_LIM_NEG_DEF   24'h800000
`define MCS_WRAP_RANGE_DEF     24'h0003e8
`define MCS_OT_EN_DEF          1'b1
`define MCS_WRAP_EN_DEF        1'b0
`define MCS_STOP_MODE_DEF      2'h0
`define MCS_STOP_IMMED         2'h0
`define MCS_STOP_DECEL         2'h1
`define MCS_STOP_IMMED_OFF     2'h2
`define MCS_STOP_DECEL_OFF     2'h3
`define MCS_SPD_STEP           12'd1
`define MCS_STEP_DIV           16'd1000

`endif

//--- rtl/mcs_pkg.sv
// Types shared by the motion command sequencer files.
// Assumes the constants header sits on the include path.
`include "mcs_consts.svh"

package mcs_pkg;

  // Motion state, one-hot.
  typedef enum logic [4:0] {
    MCS_IDLE  = 5'b00001,
    MCS_RUN   = 5'b00010,
    MCS_DECEL = 5'b00100,
    MCS_JOG   = 5'b01000,
    MCS_HOLD  = 5'b10000
  } mcs_state_t;

endpackage

//--- rtl/mcs_ramp.sv
// Speed ramp: moves the present speed toward a target one unit per tick and
// emits a step pulse at a rate set by the present speed.
// Assumes a single clock, synchronous reset and a shared clock enable.
`timescale 1ns/1ns
`default_nettype none
`include "mcs_consts.svh"

module mcs_ramp
  import mcs_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  input  wire logic [`MCS_SPD_W-1:0]   target,
  input  wire logic                    halt_now,
  input  wire logic [15:0]             ramp_div,
  output logic      [`MCS_SPD_W-1:0]   speed,
  output logic                         step
);

  logic [15:0] ramp_cnt;
  logic [15:0] step_acc;
  logic [16:0] next_acc;

  // ************************************************************
  // Speed ramp
  // ************************************************************
  // One speed unit per ramp tick; a zero divider ramps every cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      speed    <= '0;
      ramp_cnt <= '0;
    end else if (clk_en) begin
      if (halt_now) begin
        speed    <= '0;
        ramp_cnt <= '0;
      end else if (ramp_cnt >= ramp_div) begin
        ramp_cnt <= '0;
        if (speed < target)
          speed <= speed + `MCS_SPD_STEP;
        else if (speed > target)
          speed <= speed - `MCS_SPD_STEP;
      end else begin
        ramp_cnt <= ramp_cnt + 16'd1;
      end
    end
  end

  // ************************************************************
  // Step generator
  // ************************************************************
  // Phase accumulator; overflow past the divider gives one step.
  assign next_acc = {1'b0, step_acc} + {5'd0, speed};

  always_ff @(posedge clock) begin
    if (rst) begin
      step_acc <= '0;
      step     <= 1'b0;
    end else if (clk_en) begin
      if (next_acc >= {1'b0, `MCS_STEP_DIV}) begin
        step_acc <= 16'(next_acc - {1'b0, `MCS_STEP_DIV});
        step     <= 1'b1;
      end else begin
        step_acc <= next_acc[15:0];
        step     <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/mcs_top.sv
// Motion command sequencer for a motor driver in position control mode.
// Assumes level inputs from a host on pins (synchronised here) and a power
// stage that takes one step pulse plus direction per commanded step.
//
// Function
// - Run input starts continuous rotation at selected speed, drops ready.
// - Select change during run ramps to the new entry's speed.
// - Releasing the run input decelerates to standstill, then ready rises.
// - Same direction asserted during deceleration accelerates again.
// - Opposite direction during deceleration stops first, then reverses.
// - Both run inputs together decelerate to a stop.
// - Moving output falls once the motor reaches standstill.
// - After a stop, ready rises only with both run inputs released.
// - Inch inputs move the configured step count in their direction.
// - Inch moves use inch speed, ramp time and torque limit settings.
// - Ready drops during an inch move, returns at completion.
// - Inch, panel inch and teaching refused under free-run or stop.
// - Panel key press moves one step; holding rotates continuously.
// - Teaching stores present position into selected entry, forces absolute.
// - Stop input stops by one of four methods, default immediate.
// - Enabled overtravel with coordinate set decelerates at either limit.
// - Software limits are signed steps, defaults +8388607 and -8388608.
// - Coordinate established only after home return or position preset.
// - Wrap resets position beyond range; range default 1000.
// - Wrap enabled disables overtravel checking.
// - Sixteen data entries selected by four binary select inputs.
`timescale 1ns/1ns
`default_nettype none
`include "mcs_consts.svh"

module mcs_top
  import mcs_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  input  wire logic                    run_positive,
  input  wire logic                    run_negative,
  input  wire logic [`MCS_SEL_W-1:0]   data_select_bits,
  input  wire logic                    inch_positive,
  input  wire logic                    inch_negative,
  input  wire logic                    stop_in,
  input  wire logic                    free_in,
  input  wire logic                    panel_test,
  input  wire logic                    panel_key_pos,
  input  wire logic                    panel_key_neg,
  input  wire logic                    teach_req,
  input  wire logic                    home_done,
  input  wire logic                    preset_req,
  input  wire logic [`MCS_POS_W-1:0]   preset_pos,
  input  wire logic                    entry_wr,
  input  wire logic [`MCS_SEL_W-1:0]   entry_idx,
  input  wire logic [`MCS_SPD_W-1:0]   entry_speed,
  input  wire logic [`MCS_SPD_W-1:0]   inch_speed,
  input  wire logic [15:0]             inch_ramp_ms,
  input  wire logic [7:0]              inch_torque,
  input  wire logic [`MCS_POS_W-1:0]   inch_steps,
  input  wire logic [1:0]              stop_mode,
  input  wire logic                    overtravel_en,
  input  wire logic [`MCS_POS_W-1:0]   soft_lim_pos,
  input  wire logic [`MCS_POS_W-1:0]   soft_lim_neg,
  input  wire logic                    wrap_en,
  input  wire logic [`MCS_POS_W-1:0]   wrap_range,
  output logic                         ready,
  output logic                         moving,
  output logic                         step_out,
  output logic                         dir_out,
  output logic                         current_on,
  output logic [7:0]                   torque_limit,
  output logic                         coord_set,
  output logic [`MCS_POS_W-1:0]        cmd_pos,
  output logic [`MCS_POS_W-1:0]        taught_pos,
  output logic                         taught_abs
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam int NS = 12;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  logic [NS-1:0] raw_in;

  assign raw_in = {run_positive, run_negative, data_select_bits, inch_positive,
                   inch_negative, stop_in, free_in, panel_key_pos, panel_key_neg};

  // Pin inputs pass two flip-flops; only the second stage is read.
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (clk_en) begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  logic       s_fwd, s_rvs, s_ip, s_in, s_stop, s_free, s_kp, s_kn;
  logic [3:0] s_sel;
  assign {s_fwd, s_rvs, s_sel, s_ip, s_in, s_stop, s_free, s_kp, s_kn} = sync2;

  // ************************************************************
  // Operation data table
  // ************************************************************
  logic [`MCS_SPD_W-1:0] entry_spd [`MCS_ENTRIES];
  logic [`MCS_POS_W-1:0] entry_pos [`MCS_ENTRIES];
  logic [`MCS_ENTRIES-1:0] entry_abs;
  logic teach_ok;

  genvar gi;
  generate
    for (gi = 0; gi < `MCS_ENTRIES; gi++) begin : g_entry
      always_ff @(posedge clock) begin
        if (rst) begin
          entry_spd[gi] <= '0;
          entry_pos[gi] <= '0;
          entry_abs[gi] <= 1'b0;
        end else if (clk_en) begin
          if (entry_wr && entry_idx == gi)
            entry_spd[gi] <= entry_speed;
          if (teach_ok && s_sel == gi) begin
            entry_pos[gi] <= cmd_pos;
            entry_abs[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Teach results of the selected entry are presented on the outputs.
  always_ff @(posedge clock) begin
    if (rst) begin
      taught_pos <= '0;
      taught_abs <= 1'b0;
    end else if (clk_en) begin
      taught_pos <= entry_pos[s_sel];
      taught_abs <= entry_abs[s_sel];
    end
  end

  // ************************************************************
  // Motion state machine
  // ************************************************************
  mcs_state_t state, next_state;
  logic [`MCS_SPD_W-1:0] speed, target;
  logic       step_pulse;
  logic       halt_now;
  logic       inhibit;
  logic       limit_hit;
  logic       jog_req, jog_dir;
  logic [`MCS_POS_W-1:0] jog_left;
  logic       key_prev;
  logic       want_dir;
  logic       run_one;

  assign inhibit  = s_free | s_stop;
  assign teach_ok = teach_req & panel_test & ~inhibit & (state == MCS_IDLE);
  assign run_one  = s_fwd ^ s_rvs;
  assign want_dir = s_fwd;
  assign jog_req  = ~inhibit & (((s_ip | s_in) & ~panel_test) |
                    (panel_test & (s_kp | s_kn) & ~key_prev));
  assign jog_dir  = panel_test ? s_kp : s_ip;

  always_comb begin
    next_state = state;
    unique case (state)
      MCS_IDLE: begin
        if (run_one && !inhibit && !limit_hit)
          next_state = MCS_RUN;
        else if (jog_req)
          next_state = MCS_JOG;
      end
      MCS_RUN: begin
        if (!run_one || limit_hit || want_dir != dir_out)
          next_state = MCS_DECEL;
      end
      MCS_DECEL: begin
        if (run_one && want_dir == dir_out && !limit_hit && !inhibit)
          next_state = MCS_RUN;
        else if (speed == '0)
          next_state = MCS_HOLD;
      end
      MCS_JOG: begin
        // held key keeps moving
        // A finished move halts; ramping down here would overrun the count.
        if (jog_left == '0 && !(panel_test && (s_kp | s_kn)))
          next_state = MCS_HOLD;
        else if (limit_hit)
          next_state = MCS_DECEL;
      end
      MCS_HOLD: begin
        if (!s_fwd && !s_rvs)
          next_state = MCS_IDLE;
        else if (run_one && !inhibit && !limit_hit)
          next_state = MCS_RUN;
      end
    endcase
    if (s_stop && state != MCS_IDLE && state != MCS_HOLD)
      next_state = (stop_mode[0] && speed != '0) ? MCS_DECEL : MCS_HOLD;
  end

  always_ff @(posedge clock) begin
    if (rst)
      state <= MCS_IDLE;
    else if (clk_en)
      state <= next_state;
  end

  // Panel key history for the single-press edge.
  always_ff @(posedge clock) begin
    if (rst)
      key_prev <= 1'b0;
    else if (clk_en)
      key_prev <= s_kp | s_kn;
  end

  // Direction latches on entry to a move; it never flips while turning.
  always_ff @(posedge clock) begin
    if (rst)
      dir_out <= 1'b1;
    else if (clk_en && (state == MCS_IDLE || state == MCS_HOLD)) begin
      if (next_state == MCS_RUN)
        dir_out <= want_dir;
      else if (next_state == MCS_JOG)
        dir_out <= jog_dir;
    end
  end

  always_ff @(posedge clock) begin
    if (rst)
      jog_left <= '0;
    else if (clk_en) begin
      if (state == MCS_IDLE && next_state == MCS_JOG)
        jog_left <= panel_test ? `MCS_POS_W'(1) : inch_steps;
      else if (state == MCS_JOG && step_out && jog_left != '0)
        jog_left <= jog_left - `MCS_POS_W'(1);
    end
  end

  always_comb begin
    target = '0;
    if (state == MCS_RUN)
      target = entry_spd[s_sel];
    else if (state == MCS_JOG && (jog_left > `MCS_POS_W'(1) || panel_test))
      target = inch_speed;
    else if (state == MCS_JOG)
      target = `MCS_SPD_W'(1);
  end

  // Immediate stop codes drop speed at once; others ramp down. Hold zeroes it.
  assign halt_now = (s_stop && !stop_mode[0] && state != MCS_IDLE) || state == MCS_HOLD;

  mcs_ramp u_ramp (
    .clock    (clock),
    .rst      (rst),
    .clk_en   (clk_en),
    .target   (target),
    .halt_now (halt_now),
    .ramp_div (inch_ramp_ms),
    .speed    (speed),
    .step     (step_pulse)
  );

  // ************************************************************
  // Outputs and position
  // ************************************************************
  // ready low in motion
  always_ff @(posedge clock) begin
    if (rst) begin
      ready    <= 1'b1;
      moving   <= 1'b0;
      step_out <= 1'b0;
    end else if (clk_en) begin
      ready    <= (next_state == MCS_IDLE);
      moving   <= (next_state == MCS_RUN) || (next_state == MCS_JOG) ||
                  (next_state == MCS_DECEL);
      step_out <= step_pulse && (state != MCS_IDLE) && (state != MCS_HOLD) &&
                  (state != MCS_JOG || jog_left > `MCS_POS_W'(step_out) || (panel_test && (s_kp | s_kn)));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      current_on   <= 1'b1;
      torque_limit <= `MCS_JOG_TRQ_DEF;
    end else if (clk_en) begin
      if (s_stop && stop_mode[1] && state != MCS_IDLE)
        current_on <= 1'b0;
      else if (!s_stop && !s_free)
        current_on <= 1'b1;
      torque_limit <= (inch_torque > `MCS_JOG_TRQ_MAX) ? `MCS_JOG_TRQ_MAX : inch_torque;
    end
  end

  always_ff @(posedge clock) begin
    if (rst)
      coord_set <= 1'b0;
    else if (clk_en && (home_done || (preset_req && state == MCS_IDLE)))
      coord_set <= 1'b1;
  end

  assign limit_hit = overtravel_en && coord_set && !wrap_en &&
                     (dir_out ? ($signed(cmd_pos) >= $signed(soft_lim_pos))
                              : ($signed(cmd_pos) <= $signed(soft_lim_neg)));

  always_ff @(posedge clock) begin
    if (rst)
      cmd_pos <= '0;
    else if (clk_en) begin
      if (home_done)
        cmd_pos <= '0;
      else if (preset_req && state == MCS_IDLE)
        cmd_pos <= preset_pos;
      else if (step_out) begin
        if (wrap_en && dir_out && cmd_pos >= wrap_range - `MCS_POS_W'(1))
          cmd_pos <= '0;
        else if (wrap_en && !dir_out && cmd_pos == '0)
          cmd_pos <= wrap_range - `MCS_POS_W'(1);
        else
          cmd_pos <= dir_out ? cmd_pos + `MCS_POS_W'(1) : cmd_pos - `MCS_POS_W'(1);
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_both_on;
    s_fwd && s_rvs;
  endsequence
  sequence s_gone_idle;
    state == MCS_IDLE;
  endsequence

  property p_ready_idle;
    @(posedge clock) disable iff (rst) clk_en && (state == MCS_RUN) |=> !ready;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready high while running");

  property p_both_stop;
    @(posedge clock) disable iff (rst)
      s_both_on and (clk_en && !s_stop && state == MCS_RUN) |=> state == MCS_DECEL;
  endproperty
  a_both_stop: assert property (p_both_stop) else $error("both inputs did not decelerate");

  property p_hold_ready;
    @(posedge clock) disable iff (rst) s_gone_idle |-> !(s_fwd && s_rvs && $past(state) == MCS_HOLD);
  endproperty
  a_hold_ready: assert property (p_hold_ready) else $error("idle with run inputs held");

  property p_stop_move;
    @(posedge clock) disable iff (rst) clk_en && state == MCS_DECEL && speed == '0 && !run_one |=> !moving;
  endproperty
  a_stop_move: assert property (p_stop_move) else $error("moving high at standstill");

  property p_refuse;
    @(posedge clock) disable iff (rst) clk_en && inhibit && state == MCS_IDLE |=> state != MCS_JOG;
  endproperty
  a_refuse: assert property (p_refuse) else $error("inch accepted under stop or free");

  property p_wrap_range;
    @(posedge clock) disable iff (rst) wrap_en && $past(wrap_en) && $past(cmd_pos) < wrap_range
      && !$past(home_done) && !$past(preset_req) |-> cmd_pos < wrap_range;
  endproperty
  a_wrap_range: assert property (p_wrap_range) else $error("position left wrap range");

  property p_wrap_ot;
    @(posedge clock) disable iff (rst) wrap_en |-> !limit_hit;
  endproperty
  a_wrap_ot: assert property (p_wrap_ot) else $error("overtravel active under wrap");

  property p_coord;
    @(posedge clock) disable iff (rst) !coord_set |-> !limit_hit;
  endproperty
  a_coord: assert property (p_coord) else $error("limit without coordinate");

  property p_step_dir;
    @(posedge clock) disable iff (rst) clk_en && step_out && dir_out && !wrap_en && !home_done
      && !preset_req |=> cmd_pos == $past(cmd_pos) + `MCS_POS_W'(1);
  endproperty
  a_step_dir: assert property (p_step_dir) else $error("position not advanced");

endmodule
`default_nettype wire

//--- sim/mcs_host.sv
// Host controller model: drives the run, select and inch levels of the sequencer.
// Assumes the sequencer's clock and its ready output; callers use its tasks.
`timescale 1ns/1ns
`default_nettype none
`include "mcs_consts.svh"

module mcs_host #(
  parameter int SETTLE = 1000000
) (
  input  wire logic                  clock,
  input  wire logic                  ready,
  output logic                       run_positive,
  output logic                       run_negative,
  output logic [`MCS_SEL_W-1:0]      data_select_bits,
  output logic                       inch_positive,
  output logic                       inch_negative
);
  // ************************************************************
  // Host requests
  // ************************************************************

  // Every level starts released so nothing moves out of reset.
  initial begin
    run_positive     = 1'b0;
    run_negative     = 1'b0;
    data_select_bits = '0;
    inch_positive    = 1'b0;
    inch_negative    = 1'b0;
  end

  // settle after select
  // The default of SETTLE is 10 ms of clock; benches shorten it to keep runs brief.
  task automatic select(input logic [`MCS_SEL_W-1:0] v);
    @(posedge clock);
    data_select_bits <= v;
    repeat (SETTLE) @(posedge clock);
  endtask

  // Both run levels change together at one edge.
  task automatic run(input logic p, input logic n);
    @(posedge clock);
    run_positive <= p;
    run_negative <= n;
  endtask

  // release after ready low
  // A refused request never drops ready, so the wait gives up after a bound.
  task automatic inch(input logic pos, output logic seen);
    int i;
    @(posedge clock);
    inch_positive <= pos;
    inch_negative <= !pos;
    seen = 1'b0;
    for (i = 0; i < 40 && !seen; i++) begin
      @(posedge clock);
      seen = (ready === 1'b0);
    end
    inch_positive <= 1'b0;
    inch_negative <= 1'b0;
  endtask
endmodule

`default_nettype wire

//--- sim/mcs_top_tb_top.sv
// Self-checking bench for the motion command sequencer, one task per scenario.
// Assumes the design files and the host model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "mcs_consts.svh"

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module mcs_top_tb_top;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic clock, rst, clk_en, stop_in, free_in, panel_test, panel_key_pos, panel_key_neg;
  logic teach_req, home_done, preset_req, entry_wr, overtravel_en, wrap_en;
  logic [`MCS_SEL_W-1:0] entry_idx;
  logic [`MCS_SPD_W-1:0] entry_speed, inch_speed;
  logic [15:0]           inch_ramp_ms;
  logic [7:0]            inch_torque;
  logic [1:0]            stop_mode;
  logic [`MCS_POS_W-1:0] preset_pos, inch_steps, soft_lim_pos, soft_lim_neg, wrap_range;
  wire logic ready, moving, step_out, dir_out, current_on, coord_set, taught_abs;
  wire logic run_positive, run_negative, inch_positive, inch_negative;
  wire logic [`MCS_SEL_W-1:0] data_select_bits;
  wire logic [7:0]            torque_limit;
  wire logic [`MCS_POS_W-1:0] cmd_pos, taught_pos;
  int mismatches, total_checks, steps;

  mcs_top mcs_top_inst (.clock, .rst, .clk_en, .run_positive, .run_negative, .data_select_bits,
    .inch_positive, .inch_negative, .stop_in, .free_in, .panel_test, .panel_key_pos, .panel_key_neg,
    .teach_req, .home_done, .preset_req, .preset_pos, .entry_wr, .entry_idx, .entry_speed,
    .inch_speed, .inch_ramp_ms, .inch_torque, .inch_steps, .stop_mode, .overtravel_en,
    .soft_lim_pos, .soft_lim_neg, .wrap_en, .wrap_range, .ready, .moving, .step_out, .dir_out,
    .current_on, .torque_limit, .coord_set, .cmd_pos, .taught_pos, .taught_abs);

  // The select settle is cut to 50 cycles; the full 10 ms would dwarf the run.
  mcs_host #(.SETTLE(50)) mcs_host_inst (.clock, .ready, .run_positive, .run_negative,
    .data_select_bits, .inch_positive, .inch_negative);

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Counts commanded steps so position can be predicted from pulses.
  always @(posedge clock) begin
    if (step_out === 1'b1) steps <= steps + 1;
  end

  // Waits whole cycles, then lets the edge's updates land before sampling.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wait_stop(input int lim, output int n);
    for (n = 0; n < lim && moving !== 1'b0; n++) tick(1);
  endtask

  task automatic wait_idle;
    int n;
    for (n = 0; n < 5000 && !(ready === 1'b1 && moving === 1'b0); n++) tick(1);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    `CHK("ready", 1'b1, ready)
    `CHK("torque", 8'h64, torque_limit)
    `CHK("coord", 1'b0, coord_set)
    `CHK("pos", 24'h000000, cmd_pos)
    @(posedge clock) preset_req <= 1'b1;
    @(posedge clock) preset_req <= 1'b0;
    tick(6);
    `CHK("coord", 1'b1, coord_set)
    `CHK("pos", 24'h000010, cmd_pos)
  endtask

  task automatic t_run;
    int s0, d0, d1;
    logic [`MCS_POS_W-1:0] p0;
    mcs_host_inst.select(4'h0);
    tick(1);
    p0 = cmd_pos;
    s0 = steps;
    mcs_host_inst.run(1'b1, 1'b0);
    tick(10);
    `CHK("ready", 1'b0, ready)
    `CHK("moving", 1'b1, moving)
    `CHK("dir", 1'b1, dir_out)
    tick(300);
    d0 = steps;
    tick(200);
    d0 = steps - d0;
    mcs_host_inst.select(4'hf);
    tick(1000);
    d1 = steps;
    tick(200);
    d1 = steps - d1;
    `CHK("faster", 1'b1, d1 > 4 * d0)
    mcs_host_inst.run(1'b0, 1'b0);
    wait_idle;
    `CHK("ready", 1'b1, ready)
    `CHK("moving", 1'b0, moving)
    `CHK("pos", p0 + 24'(steps - s0), cmd_pos)
  endtask

  task automatic t_dir;
    int n;
    logic [`MCS_POS_W-1:0] p;
    mcs_host_inst.select(4'h0);
    mcs_host_inst.run(1'b1, 1'b0);
    tick(300);
    mcs_host_inst.run(1'b0, 1'b0);
    tick(20);
    mcs_host_inst.run(1'b1, 1'b0);
    tick(300);
    `CHK("moving", 1'b1, moving)
    mcs_host_inst.run(1'b0, 1'b0);
    tick(20);
    p = cmd_pos;
    mcs_host_inst.run(1'b0, 1'b1);
    tick(400);
    `CHK("dir", 1'b0, dir_out)
    `CHK("back", 1'b1, $signed(cmd_pos) < $signed(p))
    mcs_host_inst.run(1'b1, 1'b1);
    tick(5);
    wait_stop(2000, n);
    `CHK("moving", 1'b0, moving)
    tick(20);
    `CHK("ready", 1'b0, ready)
    mcs_host_inst.run(1'b0, 1'b0);
    tick(10);
    `CHK("ready", 1'b1, ready)
  endtask

  task automatic t_inch;
    logic seen;
    logic [`MCS_POS_W-1:0] p;
    int k;
    @(posedge clock);
    inch_steps <= 24'h000005;
    inch_torque <= 8'h96;
    tick(1);
    p = cmd_pos;
    mcs_host_inst.inch(1'b1, seen);
    `CHK("seen", 1'b1, seen)
    tick(1);
    `CHK("torque", 8'h96, torque_limit)
    wait_idle;
    `CHK("pos", p + 24'h000005, cmd_pos)
    `CHK("ready", 1'b1, ready)
    mcs_host_inst.inch(1'b0, seen);
    wait_idle;
    `CHK("pos", p, cmd_pos)
    for (k = 0; k < 2; k++) begin
      @(posedge clock) {stop_in, free_in} <= 2'(k + 1);
      tick(5);
      mcs_host_inst.inch(1'b1, seen);
      `CHK("refused", 1'b0, seen)
      `CHK("pos", p, cmd_pos)
      @(posedge clock) {stop_in, free_in} <= 2'h0;
    end
  endtask

  task automatic t_stop;
    int m, n;
    for (m = 0; m < 4; m++) begin
      @(posedge clock) stop_mode <= 2'(m);
      mcs_host_inst.run(1'b1, 1'b0);
      tick(300);
      @(posedge clock) stop_in <= 1'b1;
      wait_stop(1000, n);
      `CHK("moving", 1'b0, moving)
      `CHK("quick", m[0] == 1'b0, n < 10)
      `CHK("current", !m[1], current_on)
      mcs_host_inst.run(1'b0, 1'b0);
      @(posedge clock) stop_in <= 1'b0;
      wait_idle;
    end
  endtask

  task automatic t_limits;
    int n;
    logic seen;
    @(posedge clock) home_done <= 1'b1;
    @(posedge clock) home_done <= 1'b0;
    soft_lim_pos <= 24'h00001e;
    tick(6);
    `CHK("pos", 24'h000000, cmd_pos)
    mcs_host_inst.run(1'b1, 1'b0);
    tick(20);
    wait_stop(3000, n);
    `CHK("held stop", 2'h0, {moving, ready})
    mcs_host_inst.run(1'b0, 1'b0);
    wait_idle;
    // A wrap of 10 with a tight limit shows that overtravel is ignored.
    @(posedge clock);
    home_done <= 1'b1;
    wrap_en <= 1'b1;
    wrap_range <= 24'h00000a;
    soft_lim_pos <= 24'h000003;
    inch_steps <= 24'h00000f;
    @(posedge clock) home_done <= 1'b0;
    tick(6);
    mcs_host_inst.inch(1'b1, seen);
    wait_idle;
    `CHK("wrap up", 24'h000005, cmd_pos)
    @(posedge clock) inch_steps <= 24'h000007;
    mcs_host_inst.inch(1'b0, seen);
    wait_idle;
    `CHK("wrap down", 24'h000008, cmd_pos)
    @(posedge clock) wrap_en <= 1'b0;
    soft_lim_pos <= 24'h7fffff;
  endtask

  task automatic t_panel;
    logic [`MCS_POS_W-1:0] p;
    int s1;
    @(posedge clock) panel_test <= 1'b1;
    tick(3);
    p = cmd_pos;
    @(posedge clock) panel_key_pos <= 1'b1;
    @(posedge clock) panel_key_pos <= 1'b0;
    tick(300);
    `CHK("one step", p + 24'h000001, cmd_pos)
    s1 = steps;
    @(posedge clock) panel_key_neg <= 1'b1;
    tick(1500);
    `CHK("held", 1'b1, $signed(cmd_pos) < $signed(p))
    @(posedge clock) panel_key_neg <= 1'b0;
    wait_idle;
    `CHK("coord", 1'b1, coord_set)
    mcs_host_inst.select(4'h3);
    @(posedge clock) teach_req <= 1'b1;
    @(posedge clock) teach_req <= 1'b0;
    tick(6);
    `CHK("taught", p + 24'h000001 - 24'(steps - s1), taught_pos)
    `CHK("absolute", 1'b1, taught_abs)
  endtask

  // Main sequence: quiet inputs, 12 cycles of reset, entry speeds, scenarios.
  initial begin
    {rst, clk_en, overtravel_en} = 3'h7;
    {stop_in, free_in, panel_test, panel_key_pos, panel_key_neg} = 5'h00;
    {teach_req, home_done, preset_req, entry_wr, wrap_en} = 5'h00;
    {entry_idx, entry_speed, stop_mode} = '0;
    {inch_speed, inch_ramp_ms, inch_torque} = {12'h12c, 16'h0000, 8'h64};
    {preset_pos, inch_steps, soft_lim_pos} = {24'h000010, 24'h000001, 24'h7fffff};
    {soft_lim_neg, wrap_range} = {24'h800000, 24'h0003e8};
    {mismatches, total_checks} = '0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      {entry_wr, entry_idx} <= {1'b1, 4'(i)};
      entry_speed <= 12'h064 + 12'(i) * 12'h032;
    end
    @(posedge clock) entry_wr <= 1'b0;
    tick(4);
    t_reset;
    t_run;
    t_dir;
    t_inch;
    t_stop;
    t_limits;
    t_panel;
    test_done;
  end

  // The scenarios need about 9,000 cycles; 30,000 means a hang.
  initial begin
    #300000;
    mismatches++;
    test_done;
  end
endmodule

`default_nettype wire
